// ===== verilog/cbfm_params.svh
// constants of the can bus failure manager: detection counts, timeout defaults.
// assumes inclusion by the main module only.
`ifndef CBFM_PARAMS_SVH
`define CBFM_PARAMS_SVH
// pulse-count difference that declares a wire fault
`define CBFM_PULSE_DIFF 4
// consecutive pulses that end a wire fault
`define CBFM_RECOVER_PULSES 4
// default detection/recovery timeout in ns (timeout length is unspecified)
`define CBFM_TIMEOUT_NS 100000
`define CBFM_CLK_NS 4
`define CBFM_TIMEOUT_CYC ((`CBFM_TIMEOUT_NS + `CBFM_CLK_NS - 1) / `CBFM_CLK_NS)
`endif

// ===== verilog/cbfm_pkg.sv
// types of the can bus failure manager.
// assumes nothing of its surroundings.
package cbfm_pkg;
  // receiver routing
  typedef enum logic [2:0] {
    CBFM_RX_DIFF = 3'h1,
    CBFM_RX_CANH = 3'h2,
    CBFM_RX_CANL = 3'h4
  } cbfm_rx_type;
  // per-fault state for the timed cases
  typedef enum logic [2:0] {
    CBFM_ST_OK = 3'h1,
    CBFM_ST_FAULT = 3'h2,
    CBFM_ST_RECOV = 3'h4
  } cbfm_state_type;
endpackage

// ===== verilog/cbfm_timer.sv
// persistence timer: output goes high after cond held for timeout_cyc cycles.
// assumes cond is synchronous to sys_clk.
`timescale 1ns/10ps
module cbfm_timer #(
  parameter int CNT_W = 20
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [CNT_W-1:0] timeout_cyc,
  input wire logic cond,
  output logic done
);
  logic [CNT_W-1:0] cnt_ff;
  // restart on any break of the condition, so glitches never accumulate
  always_ff @(posedge sys_clk) begin
    if (srst || !cond) begin
      cnt_ff <= '0;
    end else if (cnt_ff != timeout_cyc) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign done = cond && (cnt_ff == timeout_cyc);
endmodule // cbfm_timer

// ===== verilog/cbfm_failure_manager.sv
// fault detection and management of a fault-tolerant low-speed can transceiver.
// assumes analog comparators arrive as levels synchronous to sys_clk.
//
// Overview of operation
// - driver off above 165C, back at 150C
// - normal mode: all detectors run, per-fault states
// - fault flag low on fault, high after recovery
// - cases 3,4,7 all modes; others normal only
// - canh open: count difference 4, stay differential
// - canl open: count difference 4, stay differential
// - canh to battery: timeout, canh single-ended off
// - shorts recover after recessive held one timeout
// - canl to ground: timeout, canl and termination off
// - canh to ground: count difference, stay differential
// - canl above 7.3V timeout: canl termination off
// - canl to canh: differential timeout, canh only
// - short cleared: termination on, flag low timeout
// - fault flag active low
`timescale 1ns/10ps
`include "cbfm_params.svh"
module cbfm_failure_manager #(
  parameter int TIMEOUT_CYC = `CBFM_TIMEOUT_CYC,
  parameter int CNT_W = 20
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic normal_mode,
  input wire logic temp_above_165,
  input wire logic temp_below_150,
  input wire logic canh_dominant,
  input wire logic canl_dominant,
  input wire logic canh_permanent_dom,
  input wire logic canl_permanent_dom,
  input wire logic diff_above_thresh,
  input wire logic canl_above_7v3,
  output logic driver_enable,
  output logic canh_driver_en,
  output logic canl_driver_en,
  output logic high_line_termination,
  output logic low_line_termination,
  output cbfm_pkg::cbfm_rx_type rx_select,
  output logic fault_n
);
  import cbfm_pkg::*;

  // ****************************************
  // thermal shutdown
  // ****************************************
  logic thermal_off_ff;
  // hysteresis band between the two comparators holds the last state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      thermal_off_ff <= 1'b0;
    end else if (temp_above_165) begin
      thermal_off_ff <= 1'b1;
    end else if (temp_below_150) begin
      thermal_off_ff <= 1'b0;
    end
  end

  // ****************************************
  // pulse-count detectors (cases 1,2,5-like counts, normal mode)
  // ****************************************
  logic canh_dom_d_ff, canl_dom_d_ff;
  logic [2:0] diff_cnt_ff; // pulses seen on either line alone
  logic [2:0] both_cnt_ff; // consecutive pulses seen on both lines
  logic wire_fault_ff;
  logic canh_edge, canl_edge;
  assign canh_edge = canh_dominant && !canh_dom_d_ff;
  assign canl_edge = canl_dominant && !canl_dom_d_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      canh_dom_d_ff <= 1'b0;
      canl_dom_d_ff <= 1'b0;
    end else begin
      canh_dom_d_ff <= canh_dominant;
      canl_dom_d_ff <= canl_dominant;
    end
  end
  // a pulse on one line only counts toward a wire fault; pulses on both recover
  always_ff @(posedge sys_clk) begin
    if (srst || !normal_mode) begin
      diff_cnt_ff <= 3'h0;
      both_cnt_ff <= 3'h0;
      wire_fault_ff <= 1'b0;
    end else if (canh_edge && canl_edge) begin
      diff_cnt_ff <= 3'h0;
      if (wire_fault_ff && both_cnt_ff == 3'(`CBFM_RECOVER_PULSES - 1)) begin
        wire_fault_ff <= 1'b0;
        both_cnt_ff <= 3'h0;
      end else if (wire_fault_ff) begin
        both_cnt_ff <= both_cnt_ff + 3'h1;
      end
    end else if (canh_edge ^ canl_edge) begin
      both_cnt_ff <= 3'h0;
      if (diff_cnt_ff == 3'(`CBFM_PULSE_DIFF - 1)) begin
        wire_fault_ff <= 1'b1;
      end else begin
        diff_cnt_ff <= diff_cnt_ff + 3'h1;
      end
    end
  end

  // ****************************************
  // timed detectors, one shared timeout
  // ****************************************
  localparam int NT = 4;
  logic [NT-1:0] det_cond, rec_cond, det_done, rec_done, allowed;
  logic [NT-1:0] fault_ff, short_gone;
  // index 0 canh to battery/vcc, 1 canl to ground, 2 canl to battery, 3 canl to canh
  assign det_cond = {diff_above_thresh, canl_above_7v3, canl_permanent_dom, canh_permanent_dom};
  // a short still in place must never start the recovery timer, or the state would flap
  assign rec_cond = {!diff_above_thresh,
                     !canl_above_7v3,
                     !canl_permanent_dom && !diff_above_thresh,
                     !canh_permanent_dom && !diff_above_thresh};
  assign allowed = {1'b1, normal_mode, 1'b1, 1'b1};
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_timed
      cbfm_timer #(.CNT_W(CNT_W)) u_det (
        .sys_clk(sys_clk),
        .srst(srst),
        .timeout_cyc(CNT_W'(TIMEOUT_CYC)),
        .cond(det_cond[gi] && allowed[gi] && !fault_ff[gi]),
        .done(det_done[gi])
      );
      cbfm_timer #(.CNT_W(CNT_W)) u_rec (
        .sys_clk(sys_clk),
        .srst(srst),
        .timeout_cyc(CNT_W'(TIMEOUT_CYC)),
        .cond(rec_cond[gi] && fault_ff[gi]),
        .done(rec_done[gi])
      );
      // fault held until the recessive level persists a full timeout
      always_ff @(posedge sys_clk) begin
        if (srst || !allowed[gi]) begin
          fault_ff[gi] <= 1'b0;
        end else if (det_done[gi]) begin
          fault_ff[gi] <= 1'b1;
        end else if (rec_done[gi]) begin
          fault_ff[gi] <= 1'b0;
        end
      end
      assign short_gone[gi] = fault_ff[gi] && rec_cond[gi]; // short gone, timing
    end
  endgenerate

  // ****************************************
  // output steering
  // ****************************************
  logic any_fault;
  assign any_fault = wire_fault_ff || (|fault_ff);

  // thermal shutdown removes both line drivers through one enable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      driver_enable <= 1'b1;
    end else begin
      driver_enable <= !thermal_off_ff;
    end
  end

  // canh driver off only while the canh short-high fault is held, through its recovery timeout
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      canh_driver_en <= 1'b1;
    end else begin
      canh_driver_en <= !fault_ff[0];
    end
  end

  // canl driver stays off through the whole canl-canh recovery timeout
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      canl_driver_en <= 1'b1;
    end else begin
      canl_driver_en <= !(fault_ff[1] || fault_ff[3]);
    end
  end

  // high-line termination follows the canh driver
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      high_line_termination <= 1'b1;
    end else begin
      high_line_termination <= !fault_ff[0];
    end
  end

  // canl termination returns as soon as the canl-canh short clears
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_line_termination <= 1'b1;
    end else begin
      low_line_termination <= !(fault_ff[1] || fault_ff[2] ||
                                (fault_ff[3] && !short_gone[3]));
    end
  end

  // receiver routing: a canh short wins, since canl is then the only usable line
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_select <= CBFM_RX_DIFF;
    end else if (fault_ff[0]) begin
      rx_select <= CBFM_RX_CANL;
    end else if (|fault_ff[3:1]) begin
      rx_select <= CBFM_RX_CANH;
    end else begin
      rx_select <= CBFM_RX_DIFF;
    end
  end

  // fault flag low for as long as any detector holds a fault
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fault_n <= 1'b1;
    end else begin
      fault_n <= !any_fault;
    end
  end
endmodule // cbfm_failure_manager

// ===== verification/cbfm_bus_model.sv
// bus side model: turns one-cycle requests into dominant pulses on either line.
// assumes requests are driven by the bench on the rising edge of sys_clk.
`timescale 1ns/10ps
module cbfm_bus_model (
  input wire logic sys_clk,
  input wire logic h_req,
  input wire logic l_req,
  output logic canh_dominant,
  output logic canl_dominant
);
  // registered so a pulse always spans a whole cycle, never a glitch
  always_ff @(posedge sys_clk) begin
    canh_dominant <= h_req;
    canl_dominant <= l_req;
  end
endmodule // cbfm_bus_model

// ===== verification/cbfm_failure_manager_monitor.sv
// port checker of the failure manager, bound to its top module.
// assumes the timeout parameter is 8 cycles, as the bench sets it.
`timescale 1ns/10ps
module cbfm_fm_monitor #(
  parameter int TIMEOUT_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic normal_mode,
  input wire logic temp_above_165,
  input wire logic temp_below_150,
  input wire logic canh_permanent_dom,
  input wire logic canl_permanent_dom,
  input wire logic diff_above_thresh,
  input wire logic canl_above_7v3,
  input wire logic driver_enable,
  input wire logic canh_driver_en,
  input wire logic canl_driver_en,
  input wire logic high_line_termination,
  input wire logic low_line_termination,
  input wire cbfm_pkg::cbfm_rx_type rx_select,
  input wire logic fault_n
);
  import cbfm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // repetition counts are 8 plus one edge, matching the bench timeout
  therm_off_a: assert property ($rose(temp_above_165) |-> ##[1:2] !driver_enable) else
    $error("driver still on when hot");
  therm_hold_a: assert property (!driver_enable && !temp_below_150 |=> !driver_enable) else
    $error("driver back before cooling");
  canh_short_a: assert property (canh_permanent_dom [*8] ##1 canh_permanent_dom |-> ##[1:3]
    (!canh_driver_en && !high_line_termination && rx_select == CBFM_RX_CANL)) else $error("canh");
  canl_short_a: assert property (canl_permanent_dom [*8] ##1 canl_permanent_dom |-> ##[1:3]
    (!canl_driver_en && !low_line_termination && rx_select == CBFM_RX_CANH)) else $error("canl");
  canl_batt_a: assert property ((canl_above_7v3 && normal_mode) [*8] ##1 canl_above_7v3
    |-> ##[1:3] (!low_line_termination && canh_driver_en)) else $error("canl battery");
  lines_short_a: assert property ((diff_above_thresh && !canh_permanent_dom) [*8]
    ##1 diff_above_thresh |-> ##[1:3] !canl_driver_en) else $error("lines short");
  term_back_a: assert property (!low_line_termination && !canl_permanent_dom && !canl_above_7v3
    && $fell(diff_above_thresh) |-> ##[1:2] (low_line_termination && !fault_n)) else $error("term");
  canh_recov_a: assert property (!canh_driver_en && !canh_permanent_dom && !diff_above_thresh
    ##1 (!canh_permanent_dom && !diff_above_thresh) [*8] |-> ##[1:4] canh_driver_en) else
    $error("canh no recovery");
  flag_low_a: assert property (!canh_driver_en || !canl_driver_en || rx_select != CBFM_RX_DIFF
    |-> !fault_n) else $error("flag high in fault");
endmodule // cbfm_fm_monitor
bind cbfm_failure_manager cbfm_fm_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (.*);

// ===== verification/cbfm_failure_manager_bench.sv
// self-checking bench of the failure manager with a short timeout of 8 cycles.
// assumes the bus model and the bound checker are compiled beside it.
`timescale 1ns/10ps
module cbfm_failure_manager_bench;
  import cbfm_pkg::*;
  logic sys_clk, srst, normal_mode, temp_above_165, temp_below_150, h_req, l_req;
  logic canh_dominant, canl_dominant, canh_permanent_dom, canl_permanent_dom;
  logic diff_above_thresh, canl_above_7v3, driver_enable, canh_driver_en, canl_driver_en;
  logic high_line_termination, low_line_termination, fault_n;
  cbfm_rx_type rx_select;
  int error_cnt = 0;
  int samples_checked = 0;
  cbfm_failure_manager #(.TIMEOUT_CYC(8)) u_dut (.*);
  cbfm_bus_model u_bus (.*);
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic ok, input int id);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t check %0d", $time, id);
    end
  endtask
  task pulse(input logic h, input logic l);
    @(posedge sys_clk) begin
      h_req <= h;
      l_req <= l;
    end
    @(posedge sys_clk) begin
      h_req <= 0;
      l_req <= 0;
    end
  endtask
  task t_therm;
    @(posedge sys_clk) begin temp_above_165 <= 1; temp_below_150 <= 0; end
    w(3); chk(driver_enable === 1'b0, 1);
    @(posedge sys_clk) temp_above_165 <= 0;
    w(5); chk(driver_enable === 1'b0, 2);
    @(posedge sys_clk) temp_below_150 <= 1;
    w(3); chk(driver_enable === 1'b1, 3);
  endtask
  task t_canh;
    @(posedge sys_clk) canh_permanent_dom <= 1;
    w(7); chk(fault_n === 1'b1, 4);
    w(4); chk({canh_driver_en, high_line_termination, canl_driver_en, fault_n} === 4'h2, 5);
    @(posedge sys_clk) canh_permanent_dom <= 0;
    w(16); chk({canh_driver_en, high_line_termination, fault_n} === 3'h7, 6);
  endtask
  task t_canl;
    @(posedge sys_clk) canl_permanent_dom <= 1;
    w(11); chk({canl_driver_en, low_line_termination, canh_driver_en, fault_n} === 4'h2, 7);
    chk(rx_select === CBFM_RX_CANH, 8);
    @(posedge sys_clk) canl_permanent_dom <= 0;
    w(16); chk({canl_driver_en, fault_n} === 2'h3 && rx_select === CBFM_RX_DIFF, 9);
  endtask
  task t_diff;
    @(posedge sys_clk) diff_above_thresh <= 1;
    w(12); chk({canl_driver_en, low_line_termination, fault_n} === 3'h0, 10);
    @(posedge sys_clk) diff_above_thresh <= 0;
    w(2); chk({canl_driver_en, low_line_termination, fault_n} === 3'h2, 11);
    w(14); chk({canl_driver_en, fault_n} === 2'h3 && rx_select === CBFM_RX_DIFF, 12);
  endtask
  task t_batt;
    @(posedge sys_clk) begin normal_mode <= 0; canl_above_7v3 <= 1; end
    w(12); chk({low_line_termination, fault_n} === 2'h3, 13);
    @(posedge sys_clk) normal_mode <= 1;
    w(12); chk({low_line_termination, canh_driver_en, fault_n} === 3'h2, 14);
    @(posedge sys_clk) canl_above_7v3 <= 0;
    w(14); chk({low_line_termination, fault_n} === 2'h3, 15);
  endtask
  task t_open;
    for (int i = 0; i < 2; i++) begin
      repeat (4) pulse(i == 0, i == 1);
      w(3); chk(fault_n === 1'b0 && rx_select === CBFM_RX_DIFF, 16);
      repeat (4) pulse(1, 1);
      w(3); chk(fault_n === 1'b1, 17);
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 500 cycles
  initial begin
    #20000;
    error_cnt++;
    final_report;
  end
  initial begin
    {srst, normal_mode, temp_below_150} = 3'h7;
    {temp_above_165, h_req, l_req, canh_permanent_dom} = 4'h0;
    {canl_permanent_dom, diff_above_thresh, canl_above_7v3} = 3'h0;
    repeat (12) @(posedge sys_clk);
    srst <= 0;
    w(1); chk(fault_n === 1'b1 && rx_select === CBFM_RX_DIFF && driver_enable === 1'b1, 0);
    t_therm;
    t_canh;
    t_canl;
    t_diff;
    t_batt;
    t_open;
    final_report;
  end
endmodule // cbfm_failure_manager_bench
